// ==== rtl/adcc_pkg.sv ====
// adcc_pkg: constants and carriers for the converter control block.
// assumes a 32-bit AXI4-Lite slave on one 200 MHz clock.
// Notes on behaviour
// - regular external trigger enable gates regular events
// - regular select picks timer, pin or soft start
// - injected external trigger enable gates injected events
// - injected select picks timer, pin or soft start
// - alignment bit selects left or right justify
// - dma enable allows dma requests
// - calibration reset self-clears when done
// - reset during conversion takes extra cycles
// - calibration start self-clears at completion
// - continuous mode repeats conversions until cleared
// - on write wakes, second on write converts
// - clearing on stops everything, powers down
// - on starts conversion only if sole change
// - sample register holds six 3-bit fields
// - sample codes map to fixed cycle counts
// - regular soft start clears when conversion begins
// - injected soft start clears when an injected conversion begins
package adcc_pkg;
    localparam logic [7:0]  ADCC_CTL2_OFFS     = 8'h08;
    localparam logic [7:0]  ADCC_SAMPLE_OFFS   = 8'h0C;
    localparam logic [7:0]  ADCC_STAT_OFFS     = 8'h40;
    localparam logic [31:0] ADCC_CTL2_RESET    = 32'h0000_0000;
    localparam logic [31:0] ADCC_CTL2_MASK     = 32'h007E_F90F;
    localparam logic [31:0] ADCC_SAMPLE_MASK   = 32'h0003_FFFF;
    localparam int          ADCC_B_ON          = 0;
    localparam int          ADCC_B_CONTINUOUS  = 1;
    localparam int          ADCC_B_CAL         = 2;
    localparam int          ADCC_B_RECAL       = 3;
    localparam int          ADCC_B_DMA         = 8;
    localparam int          ADCC_B_ALIGN       = 11;
    localparam int          ADCC_B_JSEL_LO     = 12;
    localparam int          ADCC_B_JEXT        = 15;
    localparam int          ADCC_B_RSEL_LO     = 17;
    localparam int          ADCC_B_REXT        = 20;
    localparam int          ADCC_B_JSOFT       = 21;
    localparam int          ADCC_B_RSOFT       = 22;
    localparam logic [2:0]  ADCC_SEL_PIN       = 3'h6;
    localparam logic [2:0]  ADCC_SEL_SOFT      = 3'h7;
    localparam logic [2:0]  ADCC_JSEL_T1C3     = 3'h0;
    localparam logic [2:0]  ADCC_JSEL_T2C4     = 3'h3;
    localparam int          ADCC_CONV_CYC      = 12;
    localparam int          ADCC_CAL_CYC       = 16;
    localparam int          ADCC_RECAL_CYC     = 4;
    localparam int          ADCC_RECAL_EXTRA   = 4;
    localparam logic [1:0]  ADCC_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  ADCC_RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic t1_trigger_out;
        logic t1_compare_one;
        logic t1_compare_two;
        logic t1_compare_three;
        logic t2_trigger_out;
        logic t2_compare_one;
        logic t2_compare_two;
        logic t2_compare_four;
        logic reg_pin;
        logic inj_pin;
    } adcc_evt_t;

    typedef struct packed {
        logic       busy;
        logic       injected;
        logic [3:0] channel;
        logic [7:0] sample_cycles;
    } adcc_conv_t;
endpackage : adcc_pkg

// ==== rtl/adcc_top.sv ====
// adcc_top: converter control register pair with an AXI4-Lite slave.
// assumes event inputs are asynchronous pins; conversion timing is modelled.
`timescale 1ns/1ps
module adcc_top
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_awaddr,
    input  wire logic               s_awvalid,
    output logic                    s_awready,
    input  wire logic [31:0]        s_wdata,
    input  wire logic [3:0]         s_wstrb,
    input  wire logic               s_wvalid,
    output logic                    s_wready,
    output logic [1:0]              s_bresp,
    output logic                    s_bvalid,
    input  wire logic               s_bready,
    input  wire logic [7:0]         s_araddr,
    input  wire logic               s_arvalid,
    output logic                    s_arready,
    output logic [31:0]             s_rdata,
    output logic [1:0]              s_rresp,
    output logic                    s_rvalid,
    input  wire logic               s_rready,
    input  wire adcc_pkg::adcc_evt_t evt_in,
    input  wire logic [3:0]         conv_channel,
    output logic                    conv_start_reg,
    output logic                    powered_reg,
    output logic                    left_align_reg,
    output logic                    dma_req_reg,
    output adcc_pkg::adcc_conv_t    conv_state_reg
);
    typedef enum logic [3:0] {
        ADCC_OFF  = 4'h1,
        ADCC_IDLE = 4'h2,
        ADCC_CONV = 4'h4,
        ADCC_CAL  = 4'h8
    } adcc_state_t;

    adcc_state_t state_reg;
    logic [31:0] ctl_reg;
    logic [31:0] smp_reg;
    logic [9:0]  evt_s1_reg;
    logic [9:0]  evt_s2_reg;
    logic [9:0]  evt_s3_reg;
    logic [7:0]  cnt_reg;
    logic [3:0]  rc_cnt_reg;
    logic        rc_extra_reg;
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        reg_start;
    logic        inj_start;
    logic        on_start;
    logic        wr_fire;
    logic        wr_ctl;
    logic [31:0] wr_val;
    logic [9:0]  rise;

    // per-code cycle table
    function automatic logic [7:0] adcc_cycles(input logic [2:0] code);
        case (code)
            3'h0:    adcc_cycles = 8'h03;
            3'h1:    adcc_cycles = 8'h09;
            3'h2:    adcc_cycles = 8'h0F;
            3'h3:    adcc_cycles = 8'h1E;
            3'h4:    adcc_cycles = 8'h2B;
            3'h5:    adcc_cycles = 8'h39;
            3'h6:    adcc_cycles = 8'h49;
            default: adcc_cycles = 8'hF1;
        endcase
    endfunction : adcc_cycles

    function automatic logic [31:0] adcc_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        for (int i = 0; i < 4; i++)
        begin
            adcc_merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
        end
    endfunction : adcc_merge

    // --- AXI4-Lite write channel: address and data taken in either order
    assign wr_fire = aw_got_reg && w_got_reg && !s_bvalid;
    assign wr_ctl  = wr_fire && aw_addr_reg == adcc_pkg::ADCC_CTL2_OFFS;
    assign wr_val  = adcc_merge(ctl_reg, w_data_reg, w_strb_reg) & adcc_pkg::ADCC_CTL2_MASK;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            s_awready   <= 1'b0;
            s_wready    <= 1'b0;
            s_bvalid    <= 1'b0;
            s_bresp     <= adcc_pkg::ADCC_RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end
        else
        begin
            s_awready <= !aw_got_reg && !s_awready && s_awvalid;
            s_wready  <= !w_got_reg && !s_wready && s_wvalid;
            if (s_awvalid && s_awready)
            begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_wdata;
                w_strb_reg <= s_wstrb;
            end
            if (wr_fire)
            begin
                s_bvalid   <= 1'b1;
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                s_bresp    <= (aw_addr_reg == adcc_pkg::ADCC_CTL2_OFFS ||
                               aw_addr_reg == adcc_pkg::ADCC_SAMPLE_OFFS)
                              ? adcc_pkg::ADCC_RESP_OKAY : adcc_pkg::ADCC_RESP_SLVERR;
            end
            else if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // --- AXI4-Lite read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= adcc_pkg::ADCC_RESP_OKAY;
        end
        else
        begin
            s_arready <= !s_arready && !s_rvalid && s_arvalid;
            if (s_arvalid && s_arready)
            begin
                s_rvalid <= 1'b1;
                s_rresp  <= adcc_pkg::ADCC_RESP_OKAY;
                case (s_araddr)
                    adcc_pkg::ADCC_CTL2_OFFS: s_rdata <= ctl_reg;
                    adcc_pkg::ADCC_SAMPLE_OFFS: s_rdata <= smp_reg;
                    adcc_pkg::ADCC_STAT_OFFS: s_rdata <= {28'h0, state_reg};
                    default:
                    begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= adcc_pkg::ADCC_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // --- event synchronisers and rising-edge detect
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            evt_s1_reg <= 10'h000;
            evt_s2_reg <= 10'h000;
            evt_s3_reg <= 10'h000;
        end
        else
        begin
            evt_s1_reg <= evt_in;
            evt_s2_reg <= evt_s1_reg;
            evt_s3_reg <= evt_s2_reg;
        end
    end
    assign rise = evt_s2_reg & ~evt_s3_reg;

    // bit order follows adcc_evt_t: t1_trigger_out is bit 9 down to inj_pin bit 0
    always_comb
    begin
        logic [2:0] rs;
        logic [2:0] js;
        rs = ctl_reg[adcc_pkg::ADCC_B_RSEL_LO +: 3];
        js = ctl_reg[adcc_pkg::ADCC_B_JSEL_LO +: 3];
        reg_start = 1'b0;
        inj_start = 1'b0;
        if (ctl_reg[adcc_pkg::ADCC_B_REXT] && state_reg != ADCC_OFF)
        begin
            case (rs)
                3'h0:    reg_start = rise[9];
                3'h1:    reg_start = rise[8];
                3'h2:    reg_start = rise[7];
                3'h3:    reg_start = rise[5];
                3'h4:    reg_start = rise[4];
                3'h5:    reg_start = rise[3];
                adcc_pkg::ADCC_SEL_PIN: reg_start = rise[1];
                default: reg_start = ctl_reg[adcc_pkg::ADCC_B_RSOFT];
            endcase
        end
        if (ctl_reg[adcc_pkg::ADCC_B_JEXT] && state_reg != ADCC_OFF)
        begin
            case (js)
                adcc_pkg::ADCC_JSEL_T1C3: inj_start = rise[6];
                adcc_pkg::ADCC_JSEL_T2C4: inj_start = rise[2];
                adcc_pkg::ADCC_SEL_PIN:   inj_start = rise[0];
                adcc_pkg::ADCC_SEL_SOFT:  inj_start = ctl_reg[adcc_pkg::ADCC_B_JSOFT];
                default:                  inj_start = 1'b0;
            endcase
        end
    end

    // on rewritten while already on, nothing else changing
    assign on_start = wr_ctl && ctl_reg[adcc_pkg::ADCC_B_ON] && wr_val[adcc_pkg::ADCC_B_ON]
                      && (wr_val == ctl_reg);

    // --- control register; hardware clears win over software writes of the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_reg <= adcc_pkg::ADCC_CTL2_RESET;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctl_reg <= wr_val;
            end
            if (state_reg == ADCC_IDLE && (reg_start || on_start))
            begin
                ctl_reg[adcc_pkg::ADCC_B_RSOFT] <= 1'b0;
            end
            if (state_reg == ADCC_IDLE && inj_start && !reg_start && !on_start)
            begin
                ctl_reg[adcc_pkg::ADCC_B_JSOFT] <= 1'b0;
            end
            if (state_reg == ADCC_CAL && cnt_reg == 8'h01)
            begin
                ctl_reg[adcc_pkg::ADCC_B_CAL] <= 1'b0;
            end
            if (ctl_reg[adcc_pkg::ADCC_B_RECAL] && rc_cnt_reg == 4'h1)
            begin
                ctl_reg[adcc_pkg::ADCC_B_RECAL] <= 1'b0;
            end
            if (wr_ctl && !wr_val[adcc_pkg::ADCC_B_ON])
            begin
                ctl_reg[adcc_pkg::ADCC_B_CAL]   <= 1'b0;
                ctl_reg[adcc_pkg::ADCC_B_RECAL] <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            smp_reg <= 32'h0000_0000;
        end
        else if (wr_fire && aw_addr_reg == adcc_pkg::ADCC_SAMPLE_OFFS)
        begin
            smp_reg <= adcc_merge(smp_reg, w_data_reg, w_strb_reg)
                       & adcc_pkg::ADCC_SAMPLE_MASK;
        end
    end

    // calibration-register reset counter, longer when begun mid-conversion
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rc_cnt_reg   <= 4'h0;
            rc_extra_reg <= 1'b0;
        end
        else if (!ctl_reg[adcc_pkg::ADCC_B_RECAL])
        begin
            rc_cnt_reg   <= 4'h0;
            rc_extra_reg <= 1'b0;
        end
        else if (rc_cnt_reg == 4'h0 && !rc_extra_reg)
        begin
            rc_extra_reg <= 1'b1;
            rc_cnt_reg   <= (state_reg == ADCC_CONV)
                ? 4'(adcc_pkg::ADCC_RECAL_CYC + adcc_pkg::ADCC_RECAL_EXTRA)
                : 4'(adcc_pkg::ADCC_RECAL_CYC);
        end
        else if (rc_cnt_reg != 4'h0)
        begin
            rc_cnt_reg <= rc_cnt_reg - 4'h1;
        end
    end

    // --- converter sequencing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg      <= ADCC_OFF;
            cnt_reg        <= 8'h00;
            conv_start_reg <= 1'b0;
            conv_state_reg <= '0;
        end
        else
        begin
            conv_start_reg <= 1'b0;
            case (state_reg)
                ADCC_OFF:
                begin
                    if (wr_ctl && wr_val[adcc_pkg::ADCC_B_ON])
                    begin
                        state_reg <= ADCC_IDLE;
                    end
                end
                ADCC_IDLE:
                begin
                    if (reg_start || inj_start || on_start)
                    begin
                        state_reg      <= ADCC_CONV;
                        conv_start_reg <= 1'b1;
                        cnt_reg        <= 8'(adcc_pkg::ADCC_CONV_CYC)
                                          + adcc_cycles(smp_reg[2:0]);
                        conv_state_reg <= '{busy: 1'b1,
                                            injected: !(reg_start || on_start),
                                            channel: conv_channel,
                                            sample_cycles: adcc_cycles(smp_reg[2:0])};
                        if (conv_channel >= 4'hA && conv_channel <= 4'hF)
                        begin
                            cnt_reg <= 8'(adcc_pkg::ADCC_CONV_CYC) + adcc_cycles(
                                smp_reg[3*(conv_channel - 4'hA) +: 3]);
                            conv_state_reg.sample_cycles <= adcc_cycles(
                                smp_reg[3*(conv_channel - 4'hA) +: 3]);
                        end
                    end
                    else if (ctl_reg[adcc_pkg::ADCC_B_CAL])
                    begin
                        state_reg <= ADCC_CAL;
                        cnt_reg   <= 8'(adcc_pkg::ADCC_CAL_CYC);
                    end
                end
                ADCC_CONV:
                begin
                    if (cnt_reg == 8'h01)
                    begin
                        // continuous mode rearms without a fresh trigger
                        if (ctl_reg[adcc_pkg::ADCC_B_CONTINUOUS])
                        begin
                            cnt_reg        <= 8'(adcc_pkg::ADCC_CONV_CYC)
                                              + conv_state_reg.sample_cycles;
                            conv_start_reg <= 1'b1;
                        end
                        else
                        begin
                            state_reg           <= ADCC_IDLE;
                            conv_state_reg.busy <= 1'b0;
                        end
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                ADCC_CAL:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg == 8'h01)
                    begin
                        state_reg <= ADCC_IDLE;
                    end
                end
                default: state_reg <= ADCC_OFF;
            endcase
            if (wr_ctl && !wr_val[adcc_pkg::ADCC_B_ON])
            begin
                state_reg           <= ADCC_OFF;
                conv_state_reg.busy <= 1'b0;
                conv_start_reg      <= 1'b0;
            end
        end
    end

    // dma request pulses when a conversion finishes, only if enabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            powered_reg    <= 1'b0;
            left_align_reg <= 1'b0;
            dma_req_reg    <= 1'b0;
        end
        else
        begin
            powered_reg    <= state_reg != ADCC_OFF;
            left_align_reg <= ctl_reg[adcc_pkg::ADCC_B_ALIGN];
            dma_req_reg    <= ctl_reg[adcc_pkg::ADCC_B_DMA] && state_reg == ADCC_CONV
                              && cnt_reg == 8'h01;
        end
    end

    chk_off_no_start: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ADCC_OFF |=> !conv_start_reg) else $error("start while off");
    chk_dma_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        dma_req_reg |-> $past(ctl_reg[adcc_pkg::ADCC_B_DMA]))
        else $error("dma without enable");
    chk_off_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctl && !wr_val[adcc_pkg::ADCC_B_ON] |=> state_reg == ADCC_OFF)
        else $error("off ignored");
    chk_rsoft_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ADCC_IDLE && reg_start && !wr_ctl |=> !ctl_reg[adcc_pkg::ADCC_B_RSOFT])
        else $error("soft start stuck");
    chk_wake_only: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ADCC_OFF && wr_ctl && wr_val[adcc_pkg::ADCC_B_ON]
        |=> state_reg == ADCC_IDLE && !conv_start_reg) else $error("wake failed");
    // a write that changes other bits must not start a conversion from idle
    chk_sole_change: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ADCC_IDLE && wr_ctl && wr_val != ctl_reg && !reg_start && !inj_start
        |=> !conv_start_reg) else $error("multi-bit start");
    chk_cal_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_reg == ADCC_CAL) |-> ##[1:20] state_reg != ADCC_CAL)
        else $error("cal too long");
    chk_smp_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        (smp_reg & ~adcc_pkg::ADCC_SAMPLE_MASK) == 32'h0000_0000) else $error("reserved set");
    chk_align_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> left_align_reg == $past(ctl_reg[adcc_pkg::ADCC_B_ALIGN]))
        else $error("align lag");
    chk_recal_long: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ctl_reg[adcc_pkg::ADCC_B_RECAL]) && state_reg == ADCC_CONV
        |=> rc_cnt_reg == 4'(adcc_pkg::ADCC_RECAL_CYC + adcc_pkg::ADCC_RECAL_EXTRA))
        else $error("cal reset not lengthened");
    cov_conv: cover property (@(posedge aclk) disable iff (!aresetn) conv_start_reg);
    cov_cal: cover property (@(posedge aclk) disable iff (!aresetn) state_reg == ADCC_CAL);
    cov_continuous_mode: cover property (@(posedge aclk) disable iff (!aresetn)
        conv_start_reg && $past(state_reg == ADCC_CONV));
    cov_recal_conv: cover property (@(posedge aclk) disable iff (!aresetn)
        ctl_reg[adcc_pkg::ADCC_B_RECAL] && state_reg == ADCC_CONV);
endmodule : adcc_top

// ==== verif/adcc_top_test.sv ====
// adcc_top_test: self-checking bench for the converter control block.
// assumes the dut answers on AXI4-Lite and samples its inputs at the aclk rise.
`timescale 1ns/1ps
module adcc_top_test;
    localparam logic [7:0] CTL = adcc_pkg::ADCC_CTL2_OFFS;
    localparam logic [7:0] SMP = adcc_pkg::ADCC_SAMPLE_OFFS;
    logic                  aclk = 1'b0;
    logic                  aresetn = 1'b0;
    logic [7:0]            s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0]           s_wdata = 32'h0, s_rdata, d, v;
    logic [3:0]            s_wstrb = 4'hF, conv_channel = 4'hA;
    logic                  s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic                  s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]            s_bresp, s_rresp, r;
    logic                  conv_start_reg, powered_reg, left_align_reg, dma_req_reg;
    adcc_pkg::adcc_evt_t   evt_in = '0;
    adcc_pkg::adcc_conv_t  conv_state_reg;
    int                    fail_count = 0, n_tests = 0, n_start = 0, n_dma = 0, s, m;
    int                    rsel_bit [7] = '{9, 8, 7, 5, 4, 3, 1};
    int                    jsel_bit [3] = '{6, 2, 0};
    logic [7:0]            cyc_tab [8] = '{8'h03, 8'h09, 8'h0F, 8'h1E, 8'h2B, 8'h39, 8'h49, 8'hF1};

    adcc_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .evt_in(evt_in),
        .conv_channel(conv_channel), .conv_start_reg(conv_start_reg),
        .powered_reg(powered_reg), .left_align_reg(left_align_reg),
        .dma_req_reg(dma_req_reg), .conv_state_reg(conv_state_reg));

    initial forever #2.5 aclk = ~aclk;

    always @(posedge aclk)
    begin
        if (conv_start_reg === 1'b1) n_start++;
        if (dma_req_reg === 1'b1) n_dma++;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic hang;
        fail_count++;
        $display("[FAIL] t=%0t seen %h expected %h", $time, 32'h0, 32'h1);
        stop_test();
    endtask : hang

    // aw and w are offered together and each is dropped on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        int i;
        @(posedge aclk);
        s_awaddr <= a; s_awvalid <= 1; s_wdata <= dv; s_wvalid <= 1; s_bready <= 1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 0;
            if (s_wvalid && s_wready) s_wvalid <= 0;
            if (s_bvalid === 1'b1) begin r = s_bresp; s_bready <= 0; break; end
        end
        if (i == 100) hang();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge aclk);
        s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 0;
            if (s_rvalid === 1'b1) begin d = s_rdata; r = s_rresp; s_rready <= 0; break; end
        end
        if (i == 100) hang();
    endtask : rd

    task automatic wait_busy(input logic b);
        int i;
        for (i = 0; i < 400 && conv_state_reg.busy !== b; i++) @(posedge aclk);
        if (i == 400) hang();
    endtask : wait_busy

    // config write changes more than the on bit, so only the event may start
    task automatic ext_try(input logic [31:0] cfg, input int b, input int exp);
        wr(CTL, cfg | 32'h1);
        s = n_start;
        @(posedge aclk);
        evt_in[b] <= 1'b1;
        repeat (3) @(posedge aclk);
        evt_in <= '0;
        repeat (8) @(posedge aclk);
        check(32'(n_start - s), 32'(exp));
        wait_busy(0);
    endtask : ext_try

    initial
    begin
        void'($urandom(38));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTL); check(d, 32'h0);
        rd(SMP); check(d, 32'h0);
        rd(8'h20); check(32'(r), 32'(adcc_pkg::ADCC_RESP_SLVERR));
        v = $urandom;
        wr(8'h20, v);
        check(32'(r), 32'(adcc_pkg::ADCC_RESP_SLVERR));
        wr(SMP, v);
        check(32'(r), 32'(adcc_pkg::ADCC_RESP_OKAY));
        rd(SMP); check(d, v & 32'h0003_FFFF);
        $display("test registers done");
        wr(CTL, 32'h1); repeat (8) @(posedge aclk);
        check(32'(powered_reg), 32'h1); check(32'(n_start), 32'h0);
        wr(CTL, 32'h0000_0901); repeat (4) @(posedge aclk);
        check(32'(left_align_reg), 32'h1); check(32'(n_start), 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            wr(SMP, {14'h0, {6{k[2:0]}}});
            conv_channel <= 4'(10 + k % 6);
            s = n_start; m = n_dma;
            wr(CTL, 32'h0000_0901);
            wait_busy(1); check(32'(conv_state_reg.sample_cycles), 32'(cyc_tab[k]));
            check(32'(conv_state_reg.channel), 32'(10 + k % 6));
            wait_busy(0); repeat (2) @(posedge aclk);
            check(32'(n_start - s), 32'h1); check(32'(n_dma - m), 32'h1);
        end
        $display("test sample codes done");
        for (int c = 0; c < 7; c++) ext_try(32'h0010_0000 | (c << 17), rsel_bit[c], 1);
        ext_try(32'h0006_0000, 1, 0);
        for (int c = 0; c < 3; c++) ext_try(32'h0000_8000 | ((c * 3) << 12), jsel_bit[c], 1);
        ext_try(32'h0000_6000, 0, 0);
        $display("test external triggers done");
        for (int g = 0; g < 2; g++)
        begin
            v = (g != 0) ? 32'h0000_F001 : 32'h001E_0001;
            wr(CTL, v); s = n_start;
            wr(CTL, v | (32'h1 << ((g != 0) ? 21 : 22)));
            repeat (4) @(posedge aclk);
            check(32'(n_start - s), 32'h1);
            check(32'(conv_state_reg.injected), 32'(g));
            wait_busy(0); rd(CTL);
            check(32'(d[(g != 0) ? 21 : 22]), 32'h0);
        end
        $display("test soft starts done");
        wr(SMP, 32'h0); wr(CTL, 32'h3); s = n_start; wr(CTL, 32'h3);
        repeat (100) @(posedge aclk);
        check(32'(n_start - s >= 3), 32'h1);
        wr(CTL, 32'h1); wait_busy(0); s = n_start; repeat (60) @(posedge aclk);
        check(32'(n_start - s), 32'h0);
        for (int b = 2; b < 4; b++)
        begin
            // the calibration reset is issued while a conversion runs
            if (b == 3) wr(CTL, 32'h1);
            wr(CTL, 32'h1 | (32'h1 << b));
            for (int i = 0; i < 20; i++) begin rd(CTL); if (d[b] === 1'b0) break; end
            check(32'(d[b]), 32'h0);
        end
        $display("test calibration done");
        wr(CTL, 32'h1); wr(CTL, 32'h0); repeat (4) @(posedge aclk);
        check(32'(powered_reg), 32'h0); check(32'(conv_state_reg.busy), 32'h0);
        $display("test power down done");
        stop_test();
    end
endmodule : adcc_top_test
